// ===== dsdac_ahb_slave.sv
// AHB-Lite slave front end: decodes transfers into register write strobes and read captures.
// Assumes one slave on the bus, so hready is this slave's own hreadyout.

`timescale 1ns/1ps
`default_nettype none

module dsdac_ahb_slave (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	output logic                   regWrite,
	output logic [dsdac_pkg::ADDR_W-1:0] regAddr,
	output logic [31:0]            regWdata,
	input  wire logic [31:0]       regRdata
);
	import dsdac_pkg::*;

	dsdac_bus_t st_q;
	dsdac_bus_t st_d;
	logic       accept;

	// ****************************************************************
	// Transfer sequencing
	// ****************************************************************

	// Reads take one wait state so a write in the preceding data phase is always visible.
	always_comb begin
		st_d   = st_q;
		accept = hsel && htrans[1] && hready;
		if (st_q.phase == PH_RDWAIT) begin
			st_d.rdata = regRdata;
			st_d.phase = PH_RDDONE;
		end else if (accept) begin
			st_d.addr   = haddr[ADDR_W-1:0];
			st_d.wordOk = (hsize == HSIZE_WORD) && (haddr[1:0] == 2'b00);
			st_d.phase  = hwrite ? PH_WRITE : PH_RDWAIT;
		end else begin
			st_d.phase = PH_IDLE;
		end
		case (st_q.phase)
			PH_RDWAIT: hreadyout = 1'b0;
			default:   hreadyout = 1'b1;
		endcase
	end

	// Registered state.
	always_ff @(posedge clk) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Partial or misaligned writes are dropped; the response stays OKAY.
	assign regWrite = (st_q.phase == PH_WRITE) && st_q.wordOk;
	assign regAddr  = st_q.addr;
	assign regWdata = hwdata;
	assign hrdata   = st_q.rdata;
	assign hresp    = 1'b0;

endmodule // dsdac_ahb_slave

`default_nettype wire

// ===== dsdac_conv_unit.sv
// One converter's end-of-conversion pacing, done flag and result capture.
// Assumes the decimation filter delivers one-cycle done strobes with a signed code.

`timescale 1ns/1ps
`default_nettype none

module dsdac_conv_unit (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             procEnable,
	input  wire logic [1:0]       decimCode,
	input  wire logic             rawDone,
	input  wire logic [15:0]      rawCode,
	output logic                  doneFlag,
	output logic                  eocPulse,
	output logic [15:0]           result
);
	import dsdac_pkg::*;

	dsdac_conv_t st_q;
	dsdac_conv_t st_d;

	// ****************************************************************
	// Helpers
	// ****************************************************************

	// Index of the conversion that closes a decimation window.
	function automatic logic [4:0] lastIndex(input logic [1:0] code);
		case (code)
			DECIM_EVERY: lastIndex = 5'h00;
			DECIM_8:     lastIndex = LAST_OF_8;
			DECIM_16:    lastIndex = LAST_OF_16;
			default:     lastIndex = LAST_OF_32;
		endcase
	endfunction

	// Codes beyond the scaled full scale cannot come from a valid input, so they are clipped.
	function automatic logic [15:0] clampCode(input logic signed [15:0] code);
		if (code > CODE_LIMIT) begin
			clampCode = CODE_LIMIT;
		end else if (code < -CODE_LIMIT) begin
			clampCode = -CODE_LIMIT;
		end else begin
			clampCode = code;
		end
	endfunction

	// ****************************************************************
	// Next state
	// ****************************************************************

	// Count real conversions and signal only the last of each window.
	always_comb begin
		st_d       = st_q;
		st_d.pulse = 1'b0;
		if (!procEnable) begin
			st_d.count = 5'h00;
			st_d.flag  = 1'b0;
		end else if (rawDone) begin
			if (st_q.count >= lastIndex(decimCode)) begin
				st_d.count  = 5'h00;
				st_d.flag   = 1'b1;
				st_d.pulse  = 1'b1;
				st_d.result = clampCode(rawCode);
			end else begin
				st_d.count = st_q.count + 5'h01;
				st_d.flag  = 1'b0;
			end
		end
	end

	// Registered state.
	always_ff @(posedge clk) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign doneFlag = st_q.flag;
	assign eocPulse = st_q.pulse;
	assign result   = st_q.result;

endmodule // dsdac_conv_unit

`default_nettype wire

// ===== dsdac_ctrl.sv
// Top of the dual sigma-delta converter control: registers, analog-side controls, pacing.
// Assumes the modulators and decimation filters sit outside and deliver done strobes and codes.

`timescale 1ns/1ps
`default_nettype none

module dsdac_ctrl (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic              hreadyout,
	output logic              hresp,
	output logic [31:0]       hrdata,
	input  wire logic         firstRawDone,
	input  wire logic [15:0]  firstRawCode,
	input  wire logic         secondRawDone,
	input  wire logic [15:0]  secondRawCode,
	output logic              firstFrontendEnable,
	output logic              secondFrontendEnable,
	output logic              firstInputsInternal,
	output logic              secondInputsInternal,
	output logic              firstProcessingEnable,
	output logic              secondProcessingEnable,
	output logic [11:0]       firstOversamplingRatio,
	output logic [11:0]       secondOversamplingRatio,
	output logic              sharedDitherEnable,
	output logic [3:0]        sharedDitherAmplitude,
	output logic [17:0]       ditherMicrovolts,
	output logic              firstConversionIrq,
	output logic              secondConversionIrq
);
	import dsdac_pkg::*;

	dsdac_ctrl_t       ctrl_q;
	dsdac_ctrl_t       ctrl_d;
	logic              regWrite;
	logic [ADDR_W-1:0] regAddr;
	logic [31:0]       regWdata;
	logic [31:0]       regRdata;
	logic [31:0]       controlWord;
	logic [31:0]       resultsWord;
	logic [1:0]        rawDone;
	logic [15:0]       rawCode [2];
	logic [1:0]        doneFlag;
	logic [1:0]        eocPulse;
	logic [15:0]       result [2];

	// ****************************************************************
	// Helpers
	// ****************************************************************

	// Only the five documented ratio codes are legal.
	function automatic logic osrValid(input logic [3:0] code);
		osrValid = (code >= OSR_CODE_128) && (code <= OSR_CODE_2048);
	endfunction

	// Ratio for a code; an illegal code, such as the reset value, yields zero.
	function automatic logic [11:0] osrRatio(input logic [3:0] code);
		if (osrValid(code)) begin
			osrRatio = OSR_MIN_RATIO << (code - OSR_CODE_128);
		end else begin
			osrRatio = 12'h000;
		end
	endfunction

	// ****************************************************************
	// Bus slave
	// ****************************************************************

	// Register transfers arrive here as strobes and a read capture.
	dsdac_ahb_slave u_bus (
		.clk       (clk),
		.reset     (reset),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.regWrite  (regWrite),
		.regAddr   (regAddr),
		.regWdata  (regWdata),
		.regRdata  (regRdata)
	);

	// ****************************************************************
	// Control register
	// ****************************************************************

	// A write stores all control fields at once except an illegal ratio code, which is ignored, so frontend and processing can be cleared together.
	always_comb begin
		ctrl_d = ctrl_q;
		if (regWrite && (regAddr == OFS_CONTROL)) begin
			if (osrValid(regWdata[SECOND_OSR_LSB +: 4])) begin
				ctrl_d.secondOsr = regWdata[SECOND_OSR_LSB +: 4];
			end
			if (osrValid(regWdata[FIRST_OSR_LSB +: 4])) begin
				ctrl_d.firstOsr = regWdata[FIRST_OSR_LSB +: 4];
			end
			ctrl_d.ditherAmp = regWdata[DITHER_AMP_LSB +: 4];
			ctrl_d.ditherEn  = regWdata[DITHER_EN_BIT];
			ctrl_d.decim     = regWdata[DECIM_LSB +: 2];
			ctrl_d.procEn    = {regWdata[SECOND_BASE + PROC_OFS], regWdata[FIRST_BASE + PROC_OFS]};
			ctrl_d.ofsEn     = {regWdata[SECOND_BASE + OFSM_OFS], regWdata[FIRST_BASE + OFSM_OFS]};
			ctrl_d.feEn      = {regWdata[SECOND_BASE + FE_OFS], regWdata[FIRST_BASE + FE_OFS]};
		end
	end

	// Every reset brings the control fields back to their documented reset word.
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_q <= CTRL_RESET_STATE;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ****************************************************************
	// Read-back
	// ****************************************************************

	// Reserved positions are never driven, so they read as zero whatever was written.
	always_comb begin
		controlWord                                = 32'h00000000;
		controlWord[SECOND_OSR_LSB +: 4]           = ctrl_q.secondOsr;
		controlWord[DITHER_AMP_LSB +: 4]           = ctrl_q.ditherAmp;
		controlWord[DITHER_EN_BIT]                 = ctrl_q.ditherEn;
		controlWord[DECIM_LSB +: 2]                = ctrl_q.decim;
		controlWord[SECOND_BASE + DONE_OFS]        = doneFlag[1];
		controlWord[SECOND_BASE + PROC_OFS]        = ctrl_q.procEn[1];
		controlWord[SECOND_BASE + OFSM_OFS]        = ctrl_q.ofsEn[1];
		controlWord[SECOND_BASE + FE_OFS]          = ctrl_q.feEn[1];
		controlWord[FIRST_OSR_LSB +: 4]            = ctrl_q.firstOsr;
		controlWord[FIRST_BASE + DONE_OFS]         = doneFlag[0];
		controlWord[FIRST_BASE + PROC_OFS]         = ctrl_q.procEn[0];
		controlWord[FIRST_BASE + OFSM_OFS]         = ctrl_q.ofsEn[0];
		controlWord[FIRST_BASE + FE_OFS]           = ctrl_q.feEn[0];
	end

	// Offset or signal results share the word; which one it is follows the offset enable.
	assign resultsWord = {result[1], result[0]};

	// Unmapped offsets answer zero.
	always_comb begin
		case (regAddr)
			OFS_CONTROL: regRdata = controlWord;
			OFS_RESULTS: regRdata = resultsWord;
			default:     regRdata = 32'h00000000;
		endcase
	end

	// ****************************************************************
	// Converter pacing
	// ****************************************************************

	assign rawDone    = {secondRawDone, firstRawDone};
	assign rawCode[0] = firstRawCode;
	assign rawCode[1] = secondRawCode;

	// Both converters share the decimation code but count their own conversions.
	generate
		for (genvar i = 0; i < 2; i++) begin : g_conv
			dsdac_conv_unit u_conv (
				.clk        (clk),
				.reset      (reset),
				.procEnable (ctrl_q.procEn[i]),
				.decimCode  (ctrl_q.decim),
				.rawDone    (rawDone[i]),
				.rawCode    (rawCode[i]),
				.doneFlag   (doneFlag[i]),
				.eocPulse   (eocPulse[i]),
				.result     (result[i])
			);
		end
	endgenerate

	// ****************************************************************
	// Analog-side controls
	// ****************************************************************

	// The offset enable drives the input switch directly; software must not expect live input then.
	assign firstInputsInternal     = ctrl_q.ofsEn[0];
	assign secondInputsInternal    = ctrl_q.ofsEn[1];
	assign firstFrontendEnable     = ctrl_q.feEn[0];
	assign secondFrontendEnable    = ctrl_q.feEn[1];
	// Processing is not gated by the frontend; settling order is left to software.
	assign firstProcessingEnable   = ctrl_q.procEn[0];
	assign secondProcessingEnable  = ctrl_q.procEn[1];
	assign firstOversamplingRatio  = osrRatio(ctrl_q.firstOsr);
	assign secondOversamplingRatio = osrRatio(ctrl_q.secondOsr);
	assign sharedDitherEnable      = ctrl_q.ditherEn;
	assign sharedDitherAmplitude   = ctrl_q.ditherAmp;
	// Amplitude in microvolts, zero while dithering is off.
	assign ditherMicrovolts        = ctrl_q.ditherEn ? 18'(ctrl_q.ditherAmp * DITHER_STEP_UV) : 18'h00000;
	assign firstConversionIrq      = eocPulse[0];
	assign secondConversionIrq     = eocPulse[1];

endmodule // dsdac_ctrl

`default_nettype wire

// ===== dsdac_ctrl_bench.sv
// Self-checking bench for the dual converter control block.
// Assumes the filter model above and an AHB master built from tasks.

`timescale 1ns/1ps
`default_nettype none

module dsdac_ctrl_bench;
	logic clk = 1'h0, reset = 1'h1, hsel = 1'h0, hwrite = 1'h0, go1 = 1'h0, go2 = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h0;
	logic [15:0] c1 = 16'h0, c2 = 16'h0, code1, code2, irq1 = 16'h0, irq2 = 16'h0;
	logic [11:0] ratio1, ratio2;
	logic [17:0] microVolts;
	logic [3:0]  ditherAmp;
	logic hreadyout, hresp, done1, done2, fe1, fe2, int1, int2, proc1, proc2, ditherOn, irqA, irqB;
	wire logic hready = hreadyout;
	int errors = 0, comparisons = 0, cycles = 0;

	always #10 clk = ~clk;

	dsdac_filter_model m1 (.clk(clk), .go(go1), .code(c1), .rawDone(done1), .rawCode(code1));
	dsdac_filter_model m2 (.clk(clk), .go(go2), .code(c2), .rawDone(done2), .rawCode(code2));
	dsdac_ctrl uut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.firstRawDone(done1), .firstRawCode(code1), .secondRawDone(done2), .secondRawCode(code2),
		.firstFrontendEnable(fe1), .secondFrontendEnable(fe2), .firstInputsInternal(int1),
		.secondInputsInternal(int2), .firstProcessingEnable(proc1), .secondProcessingEnable(proc2),
		.firstOversamplingRatio(ratio1), .secondOversamplingRatio(ratio2), .sharedDitherEnable(ditherOn),
		.sharedDitherAmplitude(ditherAmp), .ditherMicrovolts(microVolts), .firstConversionIrq(irqA),
		.secondConversionIrq(irqB));

	// Interrupt pulses are counted here and compared by the scenarios; the ceiling cuts hangs.
	always @(posedge clk) begin
		irq1 <= irq1 + 16'(irqA === 1'h1);
		irq2 <= irq2 + 16'(irqB === 1'h1);
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			end_of_test();
		end
	end

	// ****************************************************************
	// Bus master and comparison
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Address phase held until hready, then data phase held until hready again.
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz,
		output logic [31:0] rd);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		hsize <= sz;
		@(posedge clk);
		while (hready !== 1'h1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'h1) @(posedge clk);
		rd = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'h1, a, d, 3'h2, x);
		@(posedge clk);
	endtask

	task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'h0, a, 32'h0, 3'h2, x);
		chk(x, e);
	endtask

	// Control word with both ratios valid, both frontends and processing on.
	function automatic logic [31:0] ctl(input logic [1:0] dec, input logic f);
		return {4'hB, 5'h00, dec, f, 4'h5, 4'h7, 7'h00, f, 4'h5};
	endfunction

	// Back-to-back strobes on both converters, codes stepping each time.
	task automatic fire(input int n, input logic [15:0] b1, input logic [15:0] b2);
		for (int k = 0; k < n; k++) begin
			go1 <= 1'h1;
			go2 <= 1'h1;
			c1 <= b1 + 16'(k);
			c2 <= b2 - 16'(k);
			@(posedge clk);
		end
		go1 <= 1'h0;
		go2 <= 1'h0;
		repeat (3) @(posedge clk);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset_values();
		rdchk(32'h0, 32'h04800000);
		rdchk(32'h4, 32'h00000000);
		chk({8'h00, ratio2, ratio1}, 32'h0);
		chk({14'h0, microVolts}, 32'h0000C350);
	endtask

	task automatic t_fields();
		wr(32'h0, 32'h00010001);
		wr(32'h0, 32'hBFFFBFFF);
		rdchk(32'h0, 32'hBFE7B007);
		chk({26'h0, fe1, fe2, int1, int2, proc1, proc2}, 32'h3F);
		chk({14'h0, microVolts}, 32'h0002DC6C);
		for (int i = 0; i < 5; i++) begin
			wr(32'h0, {4'(7 + i), 12'h000, 4'(11 - i), 12'h000});
			chk({8'h00, ratio2, ratio1}, {8'h00, 12'h080 << i, 12'h800 >> i});
		end
		// Codes outside the ratio table must leave both ratio fields alone.
		wr(32'h0, 32'h30003000);
		rdchk(32'h0, 32'hB0007000);
		chk({13'h0, ditherOn, microVolts}, 32'h0);
	endtask

	// Interrupt counts are judged as growth over a snapshot, so the counting process stays their only writer.
	task automatic t_decimation();
		logic [31:0] base;
		for (int c = 0; c < 4; c++) begin
			wr(32'h0, 32'hB0017001);
			wr(32'h0, ctl(2'(c), 1'h0));
			base = {irq1, irq2};
			fire(32, 16'h0100, 16'hFF00);
			chk({irq1, irq2} - base, {2{16'(32 >> (c == 0 ? 0 : c + 2))}});
			rdchk(32'h0, ctl(2'(c), 1'h1));
			rdchk(32'h4, 32'hFEE1011F);
			fire(1, 16'h0100, 16'hFF00);
			rdchk(32'h0, ctl(2'(c), 1'(c == 0)));
		end
	endtask

	// Out-of-range codes are clipped to the scaled full scale of 21844 either way.
	task automatic t_shutdown();
		logic [31:0] base;
		wr(32'h0, 32'hB0047004);
		base = {irq1, irq2};
		fire(1, 16'h7FFF, 16'h8000);
		rdchk(32'h4, 32'hAAAC5554);
		fire(2, 16'h1234, 16'h4321);
		chk({irq1, irq2} - base, 32'h00030003);
		wr(32'h0, 32'hB0007000);
		fire(2, 16'h0055, 16'h0066);
		chk({irq1, irq2} - base, 32'h00030003);
		rdchk(32'h4, 32'h43201235);
	endtask

	task automatic t_bus_and_reset();
		logic [31:0] x;
		bus(1'h1, 32'h0, 32'h0F800000, 3'h0, x);
		chk({31'h0, hresp}, 32'h0);
		rdchk(32'h0, 32'hB0007000);
		wr(32'h4, 32'hFFFFFFFF);
		rdchk(32'h4, 32'h43201235);
		rdchk(32'h10, 32'h0);
		wr(32'h0, 32'hB0077007);
		reset <= 1'h1;
		repeat (2) @(posedge clk);
		reset <= 1'h0;
		@(posedge clk);
		rdchk(32'h0, 32'h04800000);
		rdchk(32'h4, 32'h00000000);
	endtask

	task automatic end_of_test();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'h0;
		@(posedge clk);
		t_reset_values();
		t_fields();
		t_decimation();
		t_shutdown();
		t_bus_and_reset();
		end_of_test();
	end
endmodule // dsdac_ctrl_bench

bind dsdac_ctrl dsdac_ctrl_monitor mon (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
	.firstRawDone(firstRawDone), .secondRawDone(secondRawDone), .firstFrontendEnable(firstFrontendEnable),
	.secondFrontendEnable(secondFrontendEnable), .firstInputsInternal(firstInputsInternal),
	.secondInputsInternal(secondInputsInternal), .firstProcessingEnable(firstProcessingEnable),
	.secondProcessingEnable(secondProcessingEnable), .sharedDitherEnable(sharedDitherEnable),
	.sharedDitherAmplitude(sharedDitherAmplitude), .ditherMicrovolts(ditherMicrovolts),
	.firstConversionIrq(firstConversionIrq), .secondConversionIrq(secondConversionIrq));

`default_nettype wire

// ===== dsdac_ctrl_monitor.sv
// Concurrent checks on the converter control block, seen from its top ports.
// Assumes one clock, synchronous active-high reset and a single AHB slave.

`timescale 1ns/1ps
`default_nettype none

module dsdac_ctrl_monitor (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        firstRawDone,
	input wire logic        secondRawDone,
	input wire logic        firstFrontendEnable,
	input wire logic        secondFrontendEnable,
	input wire logic        firstInputsInternal,
	input wire logic        secondInputsInternal,
	input wire logic        firstProcessingEnable,
	input wire logic        secondProcessingEnable,
	input wire logic        sharedDitherEnable,
	input wire logic [3:0]  sharedDitherAmplitude,
	input wire logic [17:0] ditherMicrovolts,
	input wire logic        firstConversionIrq,
	input wire logic        secondConversionIrq
);
	// ****************************************************************
	// Helper: a word write to the control register awaits its data.
	// ****************************************************************
	logic wrPend_q;
	always_ff @(posedge clk) begin
		if (reset) begin
			wrPend_q <= 1'h0;
		end else if (hready) begin
			wrPend_q <= hsel && htrans[1] && hwrite && haddr[13:0] == 14'h0000 && hsize == 3'h2;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Control outputs follow the written word one cycle after its data phase.
	a_frontend_follows_write: assert property (wrPend_q && hready |=>
		firstFrontendEnable == $past(hwdata[0]) && secondFrontendEnable == $past(hwdata[16]))
		else $error("frontend enable does not follow write");
	a_offset_detach_write: assert property (wrPend_q && hready |=>
		firstInputsInternal == $past(hwdata[1]) && secondInputsInternal == $past(hwdata[17]))
		else $error("input detach does not follow offset enable");
	a_processing_follows_write: assert property (wrPend_q && hready |=>
		firstProcessingEnable == $past(hwdata[2]) && secondProcessingEnable == $past(hwdata[18]))
		else $error("processing enable does not follow write");
	a_dither_follows_write: assert property (wrPend_q && hready |=>
		sharedDitherEnable == $past(hwdata[23]) && sharedDitherAmplitude == $past(hwdata[27:24]))
		else $error("dither fields do not follow write");
	a_dither_scale: assert property (ditherMicrovolts ==
		(sharedDitherEnable ? 18'(sharedDitherAmplitude) * 18'h030D4 : 18'h00000))
		else $error("dither amplitude scaling wrong");
	// An interrupt only ever follows an accepted conversion strobe.
	a_first_irq_cause: assert property (firstConversionIrq |->
		$past(firstRawDone) && $past(firstProcessingEnable)) else $error("first irq without strobe");
	a_second_irq_cause: assert property (secondConversionIrq |->
		$past(secondRawDone) && $past(secondProcessingEnable)) else $error("second irq without strobe");
	a_read_wait_once: assert property (!hreadyout |=> hreadyout)
		else $error("read wait longer than one cycle");
	a_reset_state: assert property ($past(reset) |-> sharedDitherEnable && sharedDitherAmplitude == 4'h4
		&& !firstProcessingEnable && !secondFrontendEnable && hreadyout) else $error("state after reset wrong");
	a_read_data_holds: assert property (!$past(reset) && $past(hreadyout) |-> $stable(hrdata))
		else $error("read data changed outside a read");
endmodule // dsdac_ctrl_monitor

`default_nettype wire

// ===== dsdac_filter_model.sv
// Model of one decimation filter: a one-cycle done strobe with a signed code.
// Assumes the bench asks for a strobe by raising go for one clock per conversion.

`timescale 1ns/1ps
`default_nettype none

module dsdac_filter_model (
	input wire logic        clk,
	input wire logic        go,
	input wire logic [15:0] code,
	output logic            rawDone,
	output logic [15:0]     rawCode
);
	initial rawDone = 1'h0;
	initial rawCode = 16'h0000;
	// Between strobes the code toggles, so late sampling in the design shows up.
	always @(posedge clk) begin
		rawDone <= go;
		rawCode <= go ? code : ~rawCode;
	end
endmodule // dsdac_filter_model

`default_nettype wire

// ===== dsdac_pkg.sv
// Constants, field layout and state types for the dual sigma-delta converter control block.
// Assumes a single 50 MHz clock domain and a zero-offset register window of 16 KiB.

`default_nettype none

package dsdac_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int          ADDR_W        = 14;
	localparam logic [13:0] OFS_CONTROL   = 14'h0000;
	localparam logic [13:0] OFS_RESULTS   = 14'h0004;
	localparam logic [31:0] CONTROL_RESET = 32'h04800000;
	localparam logic [31:0] RESULTS_RESET = 32'h00000000;
	localparam logic [2:0]  HSIZE_WORD    = 3'h2;

	// ****************************************************************
	// Field positions of the control and status register
	// ****************************************************************
	localparam int SECOND_OSR_LSB = 28;
	localparam int DITHER_AMP_LSB = 24;
	localparam int DITHER_EN_BIT  = 23;
	localparam int DECIM_LSB      = 21;
	localparam int SECOND_BASE    = 16;
	localparam int FIRST_OSR_LSB  = 12;
	localparam int FIRST_BASE     = 0;
	localparam int FE_OFS         = 0;
	localparam int OFSM_OFS       = 1;
	localparam int PROC_OFS       = 2;
	localparam int DONE_OFS       = 4;
	localparam int RESULT_W       = 16;

	// ****************************************************************
	// Oversampling ratio codes and decimation limits
	// ****************************************************************
	localparam logic [3:0]  OSR_CODE_128  = 4'h7;
	localparam logic [3:0]  OSR_CODE_2048 = 4'hB;
	localparam logic [11:0] OSR_MIN_RATIO = 12'h080;
	localparam logic [1:0]  DECIM_EVERY   = 2'h0;
	localparam logic [1:0]  DECIM_8       = 2'h1;
	localparam logic [1:0]  DECIM_16      = 2'h2;
	localparam logic [4:0]  LAST_OF_8     = 5'h07;
	localparam logic [4:0]  LAST_OF_16    = 5'h0F;
	localparam logic [4:0]  LAST_OF_32    = 5'h1F;

	// ****************************************************************
	// Dither and output code scaling
	// ****************************************************************
	localparam int DITHER_STEP_UV   = 12500;
	localparam int FULL_SCALE_CODE  = 16383;
	localparam int SCALE_NUM_X100   = 500;
	localparam int SCALE_DEN_X100   = 375;
	localparam logic signed [15:0] CODE_LIMIT = 16'(FULL_SCALE_CODE * SCALE_NUM_X100 / SCALE_DEN_X100);

	// ****************************************************************
	// State types
	// ****************************************************************
	typedef struct packed {
		logic [3:0] secondOsr;
		logic [3:0] firstOsr;
		logic [3:0] ditherAmp;
		logic       ditherEn;
		logic [1:0] decim;
		logic [1:0] procEn;
		logic [1:0] ofsEn;
		logic [1:0] feEn;
	} dsdac_ctrl_t;

	localparam dsdac_ctrl_t CTRL_RESET_STATE = '{
		secondOsr: CONTROL_RESET[31:28],
		firstOsr:  CONTROL_RESET[15:12],
		ditherAmp: CONTROL_RESET[27:24],
		ditherEn:  CONTROL_RESET[23],
		decim:     CONTROL_RESET[22:21],
		procEn:    {CONTROL_RESET[18], CONTROL_RESET[2]},
		ofsEn:     {CONTROL_RESET[17], CONTROL_RESET[1]},
		feEn:      {CONTROL_RESET[16], CONTROL_RESET[0]}
	};

	typedef enum logic [1:0] {
		PH_IDLE   = 2'b00,
		PH_WRITE  = 2'b01,
		PH_RDWAIT = 2'b10,
		PH_RDDONE = 2'b11
	} dsdac_phase_t;

	typedef struct packed {
		dsdac_phase_t      phase;
		logic [ADDR_W-1:0] addr;
		logic              wordOk;
		logic [31:0]       rdata;
	} dsdac_bus_t;

	typedef struct packed {
		logic [4:0]  count;
		logic        flag;
		logic        pulse;
		logic [15:0] result;
	} dsdac_conv_t;

endpackage

`default_nettype wire
